// ### design/pbc_pkg.sv
// Shared constants and types for the PLL base clock selector
package pbc_pkg;

  // Programming register image: multiplier high nibble, range low nibble
  typedef struct packed {
    logic [3:0] freq_multiplier_field;
    logic [3:0] range_multiplier_field;
  } pbc_prog_t;

  // Control register write image
  typedef struct packed {
    logic pll_enable;
    logic base_source_select;
  } pbc_ctrl_t;

  localparam logic [3:0] FREQ_MULT_RESET  = 4'h6;
  localparam logic [3:0] RANGE_MULT_RESET = 4'h6;
  localparam logic [3:0] MULT_ZERO        = 4'h0;
  localparam logic [3:0] MULT_ONE         = 4'h1;
  localparam logic       PLL_ENABLE_RESET = 1'b1;
  localparam logic       SELECT_RESET     = 1'b0;

  localparam logic SRC_CRYSTAL = 1'b0;
  localparam logic SRC_VCO     = 1'b1;

  // Source edges to wait on each side of a switch
  localparam int         SWITCH_EDGES = 3;
  localparam logic [1:0] SWITCH_LAST  = 2'(SWITCH_EDGES - 1);
  localparam logic [1:0] COUNT_ZERO   = 2'h0;
  localparam logic [1:0] COUNT_ONE    = 2'h1;

  typedef enum logic [2:0] {
    SW_RUN       = 3'b001,
    SW_STOP_OLD  = 3'b010,
    SW_START_NEW = 3'b100
  } pbc_sw_state_t;

endpackage

// ### design/pbc_switch.sv
// Glitch-free source switch and divide-by-two for the base clock
`timescale 1ns/1ns
module pbc_switch (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic crystal_clock_in,
  input  wire logic vco_clock_in,
  input  wire logic select_in,
  output logic      base_clock_out,
  output logic      bus_clock_out,
  output logic      active_select_out,
  output logic      switching_out
);
  import pbc_pkg::*;

  pbc_sw_state_t state_r, state_nxt;
  logic       xtal_prev_r;
  logic       vco_prev_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic       active_nxt;

  wire xtal_rise  = crystal_clock_in & ~xtal_prev_r;
  wire vco_rise   = vco_clock_in & ~vco_prev_r;
  wire cur_rise   = active_select_out ? vco_rise : xtal_rise;
  wire count_done = (count_r == SWITCH_LAST);

  // Old source is counted out before the new one is counted in
  always_comb begin
    state_nxt  = state_r;
    count_nxt  = count_r;
    active_nxt = active_select_out;
    unique case (state_r)
      SW_RUN: begin
        if (select_in != active_select_out) begin
          state_nxt = SW_STOP_OLD;
          count_nxt = COUNT_ZERO;
        end
      end
      SW_STOP_OLD: begin
        if (cur_rise) begin
          count_nxt = count_r + COUNT_ONE;
          if (count_done) begin
            state_nxt  = SW_START_NEW;
            count_nxt  = COUNT_ZERO;
            active_nxt = select_in;
          end
        end
      end
      SW_START_NEW: begin
        if (cur_rise) begin
          count_nxt = count_r + COUNT_ONE;
          if (count_done) begin
            state_nxt = SW_RUN;
            count_nxt = COUNT_ZERO;
          end
        end
      end
      default: begin
        state_nxt = SW_RUN;
        count_nxt = COUNT_ZERO;
      end
    endcase
  end

  // Toggle only while running: output frozen mid-switch
  wire base_toggle = (state_r == SW_RUN) & cur_rise;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r           <= SW_RUN;
      count_r           <= COUNT_ZERO;
      active_select_out <= SRC_CRYSTAL;
      xtal_prev_r       <= 1'b0;
      vco_prev_r        <= 1'b0;
      base_clock_out    <= 1'b0;
      bus_clock_out     <= 1'b0;
      switching_out     <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      count_r           <= count_nxt;
      active_select_out <= active_nxt;
      xtal_prev_r       <= crystal_clock_in;
      vco_prev_r        <= vco_clock_in;
      switching_out     <= (state_nxt != SW_RUN);
      if (base_toggle) begin
        base_clock_out <= ~base_clock_out;
      end
      if (base_toggle & ~base_clock_out) begin
        bus_clock_out <= ~bus_clock_out;
      end
    end
  end
endmodule

// ### design/pbc_top.sv
// PLL programming, interlocks, lock-change flag and base clock selection
//
// Notes on behaviour
// - Switch waits three crystal and three VCO edges
// - Base clock frozen while switch in progress
// - Switched clock divided by two, even duty
// - Bus clock is quarter of selected source
// - Select bit picks crystal or VCO source
// - VCO select refused while PLL is off
// - PLL turn-off refused while VCO selected
// - Enable then select, in separate writes
// - Zero range disables PLL, forces crystal
// - Zero frequency multiplier acts as one
// - Oscillator and PLL run only when enabled
// - Base clock twice bus, even duty, delivered
// - Interrupt line driven from lock detector
// - Programming writes ignored while PLL enabled
// - Select held zero when PLL off/range zero
// - Enable held set while VCO selected
// - Lock toggle sets flag; read clears it
`timescale 1ns/1ns
module pbc_top (
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  input  wire logic               oscillator_enable_in,
  input  wire logic               crystal_clock_in,
  input  wire logic               vco_clock_in,
  input  wire logic               lock_in,
  input  wire logic               irq_enable_in,
  input  wire logic               ctrl_write_in,
  input  wire pbc_pkg::pbc_ctrl_t ctrl_wdata_in,
  input  wire logic               ctrl_read_in,
  input  wire logic               prog_write_in,
  input  wire pbc_pkg::pbc_prog_t prog_wdata_in,
  output logic                    base_clock_out,
  output logic                    bus_clock_out,
  output logic                    switching_out,
  output logic                    active_select_out,
  output logic                    pll_enable_out,
  output logic                    base_source_select_out,
  output pbc_pkg::pbc_prog_t      pll_program_reg_out,
  output logic [3:0]              freq_multiplier_out,
  output logic                    pll_run_out,
  output logic                    osc_run_out,
  output logic                    lock_change_flag_out,
  output logic                    lock_change_irq_out
);
  import pbc_pkg::*;

  logic      pll_enable_r;
  logic      pll_enable_nxt;
  logic      select_r;
  logic      select_nxt;
  pbc_prog_t prog_r;
  pbc_prog_t prog_nxt;
  logic      lock_prev_r;
  logic      flag_r;
  logic      flag_nxt;
  logic      sw_base;
  logic      sw_bus;
  logic      sw_busy;
  logic      sw_active;

  // Decode of interlock conditions
  wire range_zero = (prog_r.range_multiplier_field == MULT_ZERO);
  wire freq_zero  = (prog_r.freq_multiplier_field == MULT_ZERO);
  // VCO counts as in use until the switcher has fully left it
  wire vco_in_use = select_r | sw_active | sw_busy;
  wire want_en    = ctrl_wdata_in.pll_enable;
  wire want_sel   = ctrl_wdata_in.base_source_select;

  // Select may only rise if the PLL was already on before this write
  wire sel_allowed = pll_enable_r & ~range_zero;
  // A set riding on an enable clear is refused: one bit moves per write
  wire sel_keep    = select_r | want_en;
  wire sel_written = ctrl_write_in ? (want_sel & sel_keep & sel_allowed)
                                   : select_r;
  assign select_nxt = sel_written & sel_allowed;

  // Clearing is refused while the VCO still feeds the output
  wire en_written = ctrl_write_in ? (want_en | vco_in_use)
                                  : pll_enable_r;
  assign pll_enable_nxt = en_written | select_r;

  assign prog_nxt = (prog_write_in & ~pll_enable_r) ? prog_wdata_in
                                                    : prog_r;

  // Set wins over the read-clear so a toggle is never lost
  wire lock_toggle = lock_in ^ lock_prev_r;
  assign flag_nxt = lock_toggle | (flag_r & ~ctrl_read_in);

  // Analog run enables gated by the oscillator enable
  wire pll_run_nxt = oscillator_enable_in & pll_enable_r
                     & ~range_zero;
  wire [3:0] n_nxt = freq_zero ? MULT_ONE
                               : prog_r.freq_multiplier_field;

  // Sources gated so a stopped oscillator cannot clock the output
  wire xtal_gated = crystal_clock_in & oscillator_enable_in;
  wire vco_gated  = vco_clock_in & pll_run_out;

  pbc_switch u_switch (
    .clock_in          (clock_in),
    .reset_in          (reset_in),
    .crystal_clock_in  (xtal_gated),
    .vco_clock_in      (vco_gated),
    .select_in         (select_r),
    .base_clock_out    (sw_base),
    .bus_clock_out     (sw_bus),
    .active_select_out (sw_active),
    .switching_out     (sw_busy)
  );

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pll_enable_r <= PLL_ENABLE_RESET;
      select_r     <= SELECT_RESET;
      prog_r       <= {FREQ_MULT_RESET, RANGE_MULT_RESET};
      lock_prev_r  <= 1'b0;
      flag_r       <= 1'b0;
    end else begin
      pll_enable_r <= pll_enable_nxt;
      select_r     <= select_nxt;
      prog_r       <= prog_nxt;
      lock_prev_r  <= lock_in;
      flag_r       <= flag_nxt;
    end
  end

  // Output registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      base_clock_out         <= 1'b0;
      bus_clock_out          <= 1'b0;
      switching_out          <= 1'b0;
      active_select_out      <= SRC_CRYSTAL;
      pll_enable_out         <= PLL_ENABLE_RESET;
      base_source_select_out <= SELECT_RESET;
      pll_program_reg_out    <= {FREQ_MULT_RESET, RANGE_MULT_RESET};
      freq_multiplier_out    <= FREQ_MULT_RESET;
      pll_run_out            <= 1'b0;
      osc_run_out            <= 1'b0;
      lock_change_flag_out   <= 1'b0;
      lock_change_irq_out    <= 1'b0;
    end else begin
      base_clock_out         <= sw_base;
      bus_clock_out          <= sw_bus;
      switching_out          <= sw_busy;
      active_select_out      <= sw_active;
      pll_enable_out         <= pll_enable_nxt;
      base_source_select_out <= select_nxt;
      pll_program_reg_out    <= prog_nxt;
      freq_multiplier_out    <= n_nxt;
      pll_run_out            <= pll_run_nxt;
      osc_run_out            <= oscillator_enable_in;
      lock_change_flag_out   <= flag_nxt;
      lock_change_irq_out    <= flag_nxt & irq_enable_in;
    end
  end
endmodule

// ### sim/pbc_chk.sv
// Assertion checker for the base clock selector
`timescale 1ns/1ns
module pbc_chk
  import pbc_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       reset_in,
  input wire logic       ctrl_write_in,
  input wire pbc_ctrl_t  ctrl_wdata_in,
  input wire logic       prog_write_in,
  input wire logic       lock_in,
  input wire logic       base_clock_out,
  input wire logic       switching_out,
  input wire logic       pll_enable_out,
  input wire logic       base_source_select_out,
  input wire pbc_prog_t  pll_program_reg_out,
  input wire logic [3:0] freq_multiplier_out,
  input wire logic       pll_run_out,
  input wire logic       lock_change_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  chk_vco_refused: assert property (ctrl_write_in && !pll_enable_out
    && ctrl_wdata_in.base_source_select |=> !base_source_select_out)
    else $error("select taken with pll off");
  chk_off_refused: assert property (ctrl_write_in
    && !ctrl_wdata_in.pll_enable && base_source_select_out |=> pll_enable_out)
    else $error("pll turned off under vco");
  chk_select_pll: assert property (base_source_select_out |-> pll_enable_out)
    else $error("select set without pll enable");
  chk_prog_locked: assert property (prog_write_in && pll_enable_out
    |=> $stable(pll_program_reg_out)) else $error("prog write while on");
  chk_range_zero: assert property ((pll_program_reg_out.range_multiplier_field
    == MULT_ZERO)[*2] |-> !pll_run_out && !base_source_select_out)
    else $error("zero range left pll running");
  chk_mult_alias: assert property ((pll_program_reg_out.freq_multiplier_field
    == MULT_ZERO)[*3] |-> freq_multiplier_out == MULT_ONE)
    else $error("zero multiplier not read as one");
  chk_clock_frozen: assert property (switching_out[*4]
    |-> $stable(base_clock_out)) else $error("base clock moved in switch");
  chk_lock_flag: assert property ($changed(lock_in)
    |-> ##[1:2] lock_change_flag_out) else $error("lock toggle not flagged");
  cover property ($rose(switching_out));
  cover property ($fell(base_source_select_out));
  cover property ($rose(lock_change_flag_out));
endmodule
bind pbc_top pbc_chk u_chk (.clock_in, .reset_in, .ctrl_write_in,
  .ctrl_wdata_in, .prog_write_in, .lock_in, .base_clock_out, .switching_out,
  .pll_enable_out, .base_source_select_out, .pll_program_reg_out,
  .freq_multiplier_out, .pll_run_out, .lock_change_flag_out);

// ### sim/pbc_far_model.sv
// Crystal and VCO sources that stand still while not enabled
`timescale 1ns/1ns
module pbc_far_model (
  input  wire logic clock_in,
  input  wire logic osc_run_in,
  input  wire logic pll_run_in,
  output logic      crystal_clock_out,
  output logic      vco_clock_out
);
  int xt = 0;
  int vt = 0;
  initial {crystal_clock_out, vco_clock_out} = 2'b00;
  // Periods 4 and 6 cycles, so each level is seen by the sampler
  always @(posedge clock_in) begin
    #1;
    if (osc_run_in && ++xt % 2 == 0)
      crystal_clock_out = !crystal_clock_out;
    if (pll_run_in && ++vt % 3 == 0)
      vco_clock_out = !vco_clock_out;
  end
endmodule

// ### sim/pbc_top_bench.sv
// Self-checking bench for the base clock selector
`timescale 1ns/1ns
module pbc_top_bench;
  import pbc_pkg::*;
  logic clock_in = 0, reset_in = 1, oscillator_enable_in = 1, lock_in = 0;
  logic irq_enable_in = 0, ctrl_write_in = 0, ctrl_read_in = 0;
  logic prog_write_in = 0, crystal_clock_in, vco_clock_in, base_clock_out;
  logic bus_clock_out, switching_out, active_select_out, pll_enable_out;
  logic base_source_select_out, pll_run_out, osc_run_out;
  logic lock_change_flag_out, lock_change_irq_out;
  logic [3:0] freq_multiplier_out;
  pbc_ctrl_t  ctrl_wdata_in = '0;
  pbc_prog_t  prog_wdata_in = '0;
  pbc_prog_t  pll_program_reg_out;
  int         n_errors = 0;
  int         comparisons = 0;
  always #4 clock_in = ~clock_in;
  pbc_far_model u_pbc_far_model (.clock_in, .osc_run_in(osc_run_out),
    .pll_run_in(pll_run_out), .crystal_clock_out(crystal_clock_in),
    .vco_clock_out(vco_clock_in));
  pbc_top u_pbc_top (.clock_in, .reset_in, .oscillator_enable_in,
    .crystal_clock_in, .vco_clock_in, .lock_in, .irq_enable_in,
    .ctrl_write_in, .ctrl_wdata_in, .ctrl_read_in, .prog_write_in,
    .prog_wdata_in, .base_clock_out, .bus_clock_out, .switching_out,
    .active_select_out, .pll_enable_out, .base_source_select_out,
    .pll_program_reg_out, .freq_multiplier_out, .pll_run_out, .osc_run_out,
    .lock_change_flag_out, .lock_change_irq_out);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One strobe per call, never both registers in one edge
  task automatic wr(input logic p, input logic [7:0] v);
    {prog_wdata_in, ctrl_wdata_in} = {v, v[1:0]};
    {prog_write_in, ctrl_write_in} = {p, !p};
    tick(1);
    {prog_write_in, ctrl_write_in} = 2'b00;
    tick(3);
  endtask
  task automatic wait_src(input logic s);
    int i = 0;
    while ((active_select_out !== s || switching_out !== 1'b0) && i < 80) begin
      i++;
      tick(1);
    end
    chk(8'(i < 80), 8'h01);
    if (i == 80) give_verdict();
  endtask
  // e is the count of base clock rises expected in 96 cycles
  task automatic rate(input int e);
    int b = 0, u = 0, h = 0;
    logic pb, pu;
    repeat (96) begin
      pb = base_clock_out;
      pu = bus_clock_out;
      tick(1);
      b += base_clock_out & !pb;
      u += bus_clock_out & !pu;
      h += base_clock_out;
    end
    chk(8'(b inside {[e - 1:e + 1]}), 8'h01);
    chk(8'(u inside {[e / 2 - 1:e / 2 + 1]}), 8'h01);
    chk(8'(h inside {[42:54]}), 8'h01);
  endtask
  task automatic t_lock;
    irq_enable_in = 1;
    lock_in = 1;
    tick(3);
    chk({lock_change_flag_out, lock_change_irq_out}, 8'h03);
    ctrl_read_in = 1;
    irq_enable_in = 0;
    tick(1);
    ctrl_read_in = 0;
    chk(lock_change_flag_out, 8'h00);
    lock_in = 0;
    tick(3);
    chk({lock_change_flag_out, lock_change_irq_out}, 8'h02);
  endtask
  // Oscillator enable low stops both sources and freezes the base clock
  task automatic t_osc;
    logic pb;
    oscillator_enable_in = 0;
    tick(2);
    pb = base_clock_out;
    chk({osc_run_out, pll_run_out}, 8'h00);
    tick(12);
    chk(base_clock_out, pb);
    oscillator_enable_in = 1;
    tick(2);
    chk({osc_run_out, pll_run_out}, 8'h03);
  endtask
  task automatic t_interlock;
    wr(1, 8'h37);
    chk(pll_program_reg_out, 8'h66);
    wr(0, 8'h01);
    chk({pll_enable_out, base_source_select_out}, 8'h00);
    wr(1, 8'h00);
    chk(freq_multiplier_out, 8'h01);
    wr(0, 8'h02);
    wr(0, 8'h03);
    chk({pll_run_out, base_source_select_out}, 8'h00);
    wr(0, 8'h00);
    wr(1, 8'h35);
    chk(freq_multiplier_out, 8'h03);
    wr(0, 8'h02);
    chk(pll_run_out, 8'h01);
  endtask
  task automatic t_switch;
    wr(0, 8'h03);
    chk({base_source_select_out, switching_out}, 8'h03);
    wait_src(1);
    wr(0, 8'h01);
    chk(pll_enable_out, 8'h01);
    rate(96 / 12);
    wr(0, 8'h02);
    wait_src(0);
  endtask
  initial begin
    tick(16);
    reset_in = 0;
    tick(1);
    chk({pll_enable_out, base_source_select_out, freq_multiplier_out}, 8'h26);
    t_lock();
    t_osc();
    rate(96 / 8);
    t_interlock();
    t_switch();
    give_verdict();
  end
endmodule
